/* hw/mbsup_filter.sv */
`timescale 1ns/1ns
`default_nettype none

module mbsup_filter
    import mbsup_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Control
    input wire logic tick_ms,
    input wire logic [15:0] tau_ms,
    // Data
    input wire logic [15:0] raw_in,
    output logic [15:0] filt_q
);
    logic signed [17:0] diff;
    logic signed [17:0] step;
    logic [16:0] tau_p1;

    // Per millisecond, move a 1/(tau+1) share of the gap; exact decay traded for no multiplier
    always_comb
    begin
        tau_p1 = {1'b0, tau_ms} + 17'h00001;
        diff = $signed({2'b00, raw_in}) - $signed({2'b00, filt_q});
        step = diff / $signed({1'b0, tau_p1});
    end

    // Zero time constant passes the value straight through
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            filt_q <= 16'h0000;
        else if (tau_ms == 16'h0000)
            filt_q <= raw_in;
        else if (tick_ms)
            filt_q <= 16'(filt_q + step[15:0]);
    end

endmodule : mbsup_filter

`default_nettype wire

/* hw/mbsup_pkg.sv */
package mbsup_pkg;

    // Clock and time base
    localparam int CLK_PERIOD_NS = 10;
    localparam int MS_NS = 1000000;
    localparam int CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
    localparam int TPER_UNIT_MS = 100;

    // Register addresses of the parameter set
    localparam logic [15:0] ADDR_NODE = 16'h0425;
    localparam logic [15:0] ADDR_BAUD = 16'h0426;
    localparam logic [15:0] ADDR_PARITY = 16'h0427;
    localparam logic [15:0] ADDR_STOP = 16'h0428;
    localparam logic [15:0] ADDR_TDET = 16'h0429;
    localparam logic [15:0] ADDR_RDLY = 16'h042A;
    localparam logic [15:0] ADDR_TPER = 16'h0435;
    localparam logic [15:0] ADDR_VUNIT = 16'h0436;
    localparam logic [15:0] ADDR_COMMIT = 16'h043C;
    localparam logic [15:0] ADDR_RUNENC = 16'h043D;
    localparam logic [15:0] ADDR_RELOAD = 16'h0B57;
    localparam logic [15:0] ADDR_BUSY = 16'h11A1;
    localparam logic [15:0] ADDR_FILT = 16'h11A2;
    localparam logic [15:0] ADDR_SSE = 16'h11CF;

    // Command and monitor addresses
    localparam logic [15:0] ADDR_RUNCMD = 16'h0001;
    localparam logic [15:0] ADDR_SSREQ = 16'h15DF;
    localparam logic [15:0] ADDR_VMON = 16'h0025;
    localparam logic [15:0] ADDR_FREQ_A = 16'h003E;
    localparam logic [15:0] ADDR_FREQ_B = 16'h003F;
    localparam logic [15:0] ADDR_SPD_A = 16'h0044;
    localparam logic [15:0] ADDR_SPD_B = 16'h00AC;
    localparam logic [15:0] ADDR_SPD_C = 16'h00AD;

    // Parameter slot indices
    localparam int NPARAM = 14;
    localparam logic [3:0] P_NODE = 4'h0;
    localparam logic [3:0] P_BAUD = 4'h1;
    localparam logic [3:0] P_PARITY = 4'h2;
    localparam logic [3:0] P_STOP = 4'h3;
    localparam logic [3:0] P_TDET = 4'h4;
    localparam logic [3:0] P_RDLY = 4'h5;
    localparam logic [3:0] P_TPER = 4'h6;
    localparam logic [3:0] P_VUNIT = 4'h7;
    localparam logic [3:0] P_COMMIT = 4'h8;
    localparam logic [3:0] P_RUNENC = 4'h9;
    localparam logic [3:0] P_RELOAD = 4'hA;
    localparam logic [3:0] P_BUSY = 4'hB;
    localparam logic [3:0] P_FILT = 4'hC;
    localparam logic [3:0] P_SSE = 4'hD;
    localparam logic [3:0] P_NONE = 4'hF;

    // Reset values, indexed by slot
    localparam logic [15:0] PARAM_RST [NPARAM] = '{
        16'h001F, 16'h0003, 16'h0000, 16'h0003, 16'h0001, 16'h0005, 16'h0014,
        16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000
    };

    // Stop methods on a communication fault
    localparam logic [1:0] STOP_RAMP = 2'h0;
    localparam logic [1:0] STOP_COAST = 2'h1;
    localparam logic [1:0] STOP_FAST = 2'h2;
    localparam logic [1:0] STOP_ALARM = 2'h3;

    // Parity encodings
    localparam logic [1:0] PARITY_NONE = 2'h0;
    localparam logic [1:0] PARITY_EVEN = 2'h1;
    localparam logic [1:0] PARITY_ODD = 2'h2;

    // Field values
    localparam logic [7:0] RUN_SRC_LINK = 8'h02;
    localparam logic [7:0] IN_FUNC_SSEARCH = 8'h62;
    localparam logic [15:0] VOLT_DIV = 16'h000A;
    localparam int RUN_BIT0 = 0;
    localparam int RUN_BIT1 = 1;
    localparam int SSREQ_BIT = 0;

    // Response delay states
    typedef enum logic [1:0] {
        MBSUP_DLY_IDLE = 2'b01,
        MBSUP_DLY_WAIT = 2'b10
    } mbsup_dly_t;

endpackage : mbsup_pkg

/* hw/mbsup_top.sv */
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// (RULE_01) Stop method 3: show fault, keep running, raise alarm terminal.
// (RULE_02) Detection on: raise timeout fault when no master data within period.
// (RULE_03) Timeout period 0.0 to 25.0 s, default 2.0 s.
// (RULE_04) Detection selector defaults 1; 0 suppresses fault, 1 applies stop method.
// (RULE_05) Reply waits configured delay, 0 to 65 ms, default 5 ms.
// (RULE_06) Register 0025H reports voltage in 0.1 V (unit 0) or 1 V (unit 1).
// (RULE_07) Commit mode 0: writes wait for the Enter command.
// (RULE_08) Commit mode 1: writes take effect at once.
// (RULE_09) Encoding 0: bit 0 forward run, bit 1 reverse run.
// (RULE_10) Encoding 1: bit 0 run, bit 1 direction (1 reverse).
// (RULE_11) Run decoding applies only when a run source selector is 2.
// (RULE_12) Enter while storage busy: discard if selector 0, working copy only if 1.
// (RULE_13) First-order filter, 0 to 100 ms, on frequency and speed monitors.
// (RULE_14) Reload 1 activates node, baud, parity, delay now; 0 waits for power cycle.
// (RULE_15) Reload selector clears itself after being applied.
// (RULE_16) Speed search enable makes 15DFH bit 0 a request; otherwise ignored.
// (RULE_17) Enable plus any input set to function 62 flags setting conflict.
// (RULE_18) Stop methods 0, 1, 2 are ramp, coast, fast, each with fault terminal.
// (RULE_19) Node address 0 never replies.
// (RULE_20) Parity codes: 0 none, 1 even, 2 odd.
// (RULE_21) Timeout timer restarts on each valid frame, idle when detection off.
module mbsup_top
    import mbsup_pkg::*;
#(
    parameter int CYC_MS = CYC_PER_MS,
    parameter int NUM_INPUTS = 7
)
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Register access from the frame engine
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata_q,
    output logic reg_rd_valid_q,
    // Frame events
    input wire logic frame_rx_valid,
    input wire logic [7:0] frame_node,
    input wire logic enter_cmd,
    input wire logic nv_write_avail,
    input wire logic fault_reset,
    output logic resp_tx_go_q,
    output logic nv_write_q,
    // Drive context
    input wire logic [7:0] run_source_select_primary,
    input wire logic [7:0] run_source_select_secondary,
    input wire logic [NUM_INPUTS*8-1:0] input_function_select,
    input wire logic [15:0] volt_ref_mon,
    input wire logic [15:0] freq_mon,
    input wire logic [15:0] speed_mon,
    // Supervision outputs
    output logic comm_fault_q,
    output logic stop_request_q,
    output logic [1:0] stop_method_q,
    output logic fault_terminal_q,
    output logic alarm_terminal_q,
    output logic run_fwd_q,
    output logic run_rev_q,
    output logic speed_search_req_q,
    output logic setting_conflict_error_q,
    // Active link settings
    output logic [7:0] node_address_q,
    output logic [3:0] baud_rate_select_q,
    output logic [1:0] parity_select_q,
    output logic [15:0] response_delay_q
);
    import mbsup_pkg::*;

    logic [15:0] pend_q [NPARAM];
    logic [15:0] act_q [NPARAM];
    logic [15:0] runcmd_q;
    logic [15:0] ssreq_q;
    logic [31:0] ms_cyc_q;
    logic tick_ms_q;
    logic [15:0] to_ms_q;
    logic [31:0] dly_cyc_q;
    logic [15:0] dly_ms_q;
    mbsup_dly_t dly_state_q;
    logic [15:0] freq_filt;
    logic [15:0] spd_filt;
    logic [3:0] wr_slot;
    logic commit_now;
    logic reload_now;
    logic enc_ok;
    logic conflict;
    logic [15:0] to_limit;
    logic link_src;
    logic fault_hit;

    // Address to parameter slot, used by the write and read paths
    function automatic logic [3:0] slot_of(input logic [15:0] a);
        case (a)
            ADDR_NODE: slot_of = P_NODE;
            ADDR_BAUD: slot_of = P_BAUD;
            ADDR_PARITY: slot_of = P_PARITY;
            ADDR_STOP: slot_of = P_STOP;
            ADDR_TDET: slot_of = P_TDET;
            ADDR_RDLY: slot_of = P_RDLY;
            ADDR_TPER: slot_of = P_TPER;
            ADDR_VUNIT: slot_of = P_VUNIT;
            ADDR_COMMIT: slot_of = P_COMMIT;
            ADDR_RUNENC: slot_of = P_RUNENC;
            ADDR_RELOAD: slot_of = P_RELOAD;
            ADDR_BUSY: slot_of = P_BUSY;
            ADDR_FILT: slot_of = P_FILT;
            ADDR_SSE: slot_of = P_SSE;
            default: slot_of = P_NONE;
        endcase
    endfunction : slot_of

    // Commit decisions and derived settings
    always_comb
    begin
        wr_slot = slot_of(reg_addr);
        // Busy storage with selector 0 drops the Enter entirely
        commit_now = enter_cmd && (nv_write_avail || act_q[P_BUSY][0]); // RULE_07 RULE_12
        reload_now = act_q[P_RELOAD][0]; // RULE_14
        link_src = (run_source_select_primary == RUN_SRC_LINK)
                   || (run_source_select_secondary == RUN_SRC_LINK); // RULE_11
        enc_ok = link_src;
        conflict = 1'b0;
        for (int i = 0; i < NUM_INPUTS; i++)
        begin
            if (input_function_select[i*8 +: 8] == IN_FUNC_SSEARCH)
                conflict = 1'b1;
        end
        to_limit = 16'(act_q[P_TPER] * TPER_UNIT_MS); // RULE_03
        fault_hit = act_q[P_TDET][0] && to_limit != 16'h0000 && to_ms_q >= to_limit;
    end

    // Pending copy holds what the master wrote
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < NPARAM; i++)
                pend_q[i] <= PARAM_RST[i];
        end
        else
        begin
            if (reg_wr_en && wr_slot != P_NONE)
                pend_q[wr_slot] <= reg_wdata;
            if (reload_now && !(reg_wr_en && wr_slot == P_RELOAD))
                pend_q[P_RELOAD] <= 16'h0000; // RULE_15
        end
    end

    // Active copy steers the block; Enter moves pending into it, a mode 1 write goes in directly
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < NPARAM; i++)
                act_q[i] <= PARAM_RST[i];
        end
        else
        begin
            if (commit_now)
            begin
                for (int i = 0; i < NPARAM; i++)
                    act_q[i] <= pend_q[i]; // RULE_07
            end
            // Clear before the write, so only a mode 1 write to this slot keeps it set
            if (reload_now)
                act_q[P_RELOAD] <= 16'h0000; // RULE_15
            if (reg_wr_en && wr_slot != P_NONE && act_q[P_COMMIT][0])
                act_q[wr_slot] <= reg_wdata; // RULE_08
        end
    end

    // Nonvolatile store only when storage is free
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            nv_write_q <= 1'b0;
        else
            nv_write_q <= enter_cmd && nv_write_avail; // RULE_12
    end

    // Link settings change only at reset or on a reload
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            node_address_q <= PARAM_RST[P_NODE][7:0];
            baud_rate_select_q <= PARAM_RST[P_BAUD][3:0];
            parity_select_q <= PARAM_RST[P_PARITY][1:0];
            response_delay_q <= PARAM_RST[P_RDLY];
        end
        else if (reload_now)
        begin
            node_address_q <= act_q[P_NODE][7:0]; // RULE_14
            baud_rate_select_q <= act_q[P_BAUD][3:0];
            parity_select_q <= act_q[P_PARITY][1:0]; // RULE_20
            response_delay_q <= act_q[P_RDLY];
        end
    end

    // Command registers act immediately, outside the commit scheme
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            runcmd_q <= 16'h0000;
            ssreq_q <= 16'h0000;
        end
        else if (reg_wr_en)
        begin
            if (reg_addr == ADDR_RUNCMD)
                runcmd_q <= reg_wdata;
            if (reg_addr == ADDR_SSREQ)
                ssreq_q <= reg_wdata;
        end
    end

    // Register read port, one cycle latency
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            reg_rdata_q <= 16'h0000;
            reg_rd_valid_q <= 1'b0;
        end
        else
        begin
            reg_rd_valid_q <= reg_rd_en;
            if (reg_rd_en)
            begin
                if (slot_of(reg_addr) != P_NONE)
                    reg_rdata_q <= pend_q[slot_of(reg_addr)];
                else
                begin
                    case (reg_addr)
                        ADDR_RUNCMD: reg_rdata_q <= runcmd_q;
                        ADDR_SSREQ: reg_rdata_q <= ssreq_q;
                        ADDR_VMON: reg_rdata_q <= act_q[P_VUNIT][0] ?
                            16'(volt_ref_mon / VOLT_DIV) : volt_ref_mon; // RULE_06
                        ADDR_FREQ_A, ADDR_FREQ_B: reg_rdata_q <= freq_filt; // RULE_13
                        ADDR_SPD_A, ADDR_SPD_B, ADDR_SPD_C: reg_rdata_q <= spd_filt; // RULE_13
                        default: reg_rdata_q <= 16'h0000;
                    endcase
                end
            end
        end
    end

    // Millisecond time base shared by timeout and filters
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            ms_cyc_q <= 32'h00000000;
            tick_ms_q <= 1'b0;
        end
        else if (ms_cyc_q == 32'(CYC_MS - 1))
        begin
            ms_cyc_q <= 32'h00000000;
            tick_ms_q <= 1'b1;
        end
        else
        begin
            ms_cyc_q <= ms_cyc_q + 32'h00000001;
            tick_ms_q <= 1'b0;
        end
    end

    // Timeout timer; a period of 0 never expires
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            to_ms_q <= 16'h0000;
        else if (!act_q[P_TDET][0] || frame_rx_valid)
            to_ms_q <= 16'h0000; // RULE_21
        else if (tick_ms_q && to_ms_q < to_limit)
            to_ms_q <= to_ms_q + 16'h0001;
    end

    // Fault latches until a fault reset, which loses to a timer still expired
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst || (fault_reset && !fault_hit))
        begin
            comm_fault_q <= 1'b0;
            stop_request_q <= 1'b0;
            stop_method_q <= STOP_RAMP;
            fault_terminal_q <= 1'b0;
            alarm_terminal_q <= 1'b0;
        end
        else if (fault_hit) // RULE_02 RULE_04
        begin
            comm_fault_q <= 1'b1;
            stop_method_q <= act_q[P_STOP][1:0];
            if (act_q[P_STOP][1:0] == STOP_ALARM)
                alarm_terminal_q <= 1'b1; // RULE_01
            else
            begin
                stop_request_q <= 1'b1; // RULE_18
                fault_terminal_q <= 1'b1;
            end
        end
    end

    // Reply delay, counted from the frame rather than the free tick
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            dly_state_q <= MBSUP_DLY_IDLE;
            dly_cyc_q <= 32'h00000000;
            dly_ms_q <= 16'h0000;
            resp_tx_go_q <= 1'b0;
        end
        else
        begin
            resp_tx_go_q <= 1'b0;
            case (dly_state_q)
                MBSUP_DLY_IDLE:
                begin
                    if (frame_rx_valid && node_address_q != 8'h00
                        && frame_node == node_address_q) // RULE_19
                    begin
                        dly_state_q <= MBSUP_DLY_WAIT;
                        dly_cyc_q <= 32'h00000000;
                        dly_ms_q <= 16'h0000;
                    end
                end
                MBSUP_DLY_WAIT:
                begin
                    if (dly_ms_q >= response_delay_q)
                    begin
                        resp_tx_go_q <= 1'b1; // RULE_05
                        dly_state_q <= MBSUP_DLY_IDLE;
                    end
                    else if (dly_cyc_q == 32'(CYC_MS - 1))
                    begin
                        dly_cyc_q <= 32'h00000000;
                        dly_ms_q <= dly_ms_q + 16'h0001;
                    end
                    else
                        dly_cyc_q <= dly_cyc_q + 32'h00000001;
                end
                default: dly_state_q <= MBSUP_DLY_IDLE;
            endcase
        end
    end

    // Run decode and speed search
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            run_fwd_q <= 1'b0;
            run_rev_q <= 1'b0;
            speed_search_req_q <= 1'b0;
            setting_conflict_error_q <= 1'b0;
        end
        else
        begin
            if (!enc_ok)
            begin
                run_fwd_q <= 1'b0; // RULE_11
                run_rev_q <= 1'b0;
            end
            else if (act_q[P_RUNENC][0])
            begin
                run_fwd_q <= runcmd_q[RUN_BIT0] && !runcmd_q[RUN_BIT1]; // RULE_10
                run_rev_q <= runcmd_q[RUN_BIT0] && runcmd_q[RUN_BIT1];
            end
            else
            begin
                run_fwd_q <= runcmd_q[RUN_BIT0]; // RULE_09
                run_rev_q <= runcmd_q[RUN_BIT1];
            end
            speed_search_req_q <= act_q[P_SSE][0] && ssreq_q[SSREQ_BIT]; // RULE_16
            setting_conflict_error_q <= act_q[P_SSE][0] && conflict; // RULE_17
        end
    end

    // Monitor filters on the millisecond tick
    mbsup_filter u_freq_filt (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .tick_ms(tick_ms_q),
        .tau_ms(act_q[P_FILT]),
        .raw_in(freq_mon),
        .filt_q(freq_filt)
    );

    mbsup_filter u_spd_filt (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .tick_ms(tick_ms_q),
        .tau_ms(act_q[P_FILT]),
        .raw_in(speed_mon),
        .filt_q(spd_filt)
    );

    // Checks
    sequence s_fault_seen;
        !comm_fault_q ##1 comm_fault_q;
    endsequence

    timeout_fault_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE_02
        s_fault_seen |-> $past(act_q[P_TDET][0]) && $past(to_ms_q) >= $past(to_limit))
        else $error("fault raised before the timeout ran out");
    detect_off_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE_04
        !act_q[P_TDET][0] |=> to_ms_q == 16'h0000)
        else $error("timeout timer ran with detection off");
    alarm_only_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE_01
        s_fault_seen ##0 (stop_method_q == STOP_ALARM)
        |-> alarm_terminal_q && !stop_request_q && !fault_terminal_q)
        else $error("alarm-only fault did not keep running");
    stop_fault_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE_18
        s_fault_seen ##0 (stop_method_q != STOP_ALARM) |-> stop_request_q && fault_terminal_q)
        else $error("stopping fault missing fault terminal");
    run_gate_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE_11
        !link_src |=> !run_fwd_q && !run_rev_q)
        else $error("run decoded without link source");
    run_enc1_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE_10
        link_src && act_q[P_RUNENC][0] && runcmd_q[1:0] == 2'h3 |=> run_rev_q && !run_fwd_q)
        else $error("run-direction encoding wrong");
    reload_clear_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE_15
        reload_now && !(reg_wr_en && wr_slot == P_RELOAD) && !commit_now
        |=> !act_q[P_RELOAD][0] ##0 node_address_q == $past(act_q[P_NODE][7:0]))
        else $error("reload did not apply and clear");
    no_reply_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE_19
        node_address_q == 8'h00 && dly_state_q == MBSUP_DLY_IDLE |=> dly_state_q == MBSUP_DLY_IDLE)
        else $error("node 0 started a reply");
    conflict_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE_17
        act_q[P_SSE][0] && conflict |=> setting_conflict_error_q)
        else $error("setting conflict not flagged");
    busy_drop_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE_12
        enter_cmd && !nv_write_avail && !act_q[P_BUSY][0] && !reg_wr_en
        |=> act_q[P_STOP] == $past(act_q[P_STOP]) && !nv_write_q)
        else $error("busy Enter was not discarded");

endmodule : mbsup_top

`default_nettype wire

/* tb/mbsup_master.sv */
`timescale 1ns/1ns
`default_nettype none

// Link master model: one access at a time, strobes one cycle wide
module mbsup_master (
    // Clock
    input wire logic clk_sys,
    // Register access
    output logic reg_wr_en,
    output logic reg_rd_en,
    output logic [15:0] reg_addr,
    output logic [15:0] reg_wdata,
    // Frame events
    output logic frame_rx_valid,
    output logic [7:0] frame_node,
    output logic enter_cmd
);
    initial
    begin
        {reg_wr_en, reg_rd_en, frame_rx_valid, enter_cmd} = 4'h0;
        reg_addr = 16'h0000;
        reg_wdata = 16'h0000;
        frame_node = 8'h00;
    end

    // Idle bus shows inverted values so stale data cannot pass
    task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d);
        @(negedge clk_sys);
        reg_wr_en = w;
        reg_rd_en = !w;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk_sys);
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask : acc

    // Enter only after the writes it commits
    task automatic ent();
        @(negedge clk_sys);
        enter_cmd = 1'b1;
        @(negedge clk_sys);
        enter_cmd = 1'b0;
    endtask : ent

    // One received frame for a node
    task automatic frm(input logic [7:0] n);
        @(negedge clk_sys);
        frame_rx_valid = 1'b1;
        frame_node = n;
        @(negedge clk_sys);
        frame_rx_valid = 1'b0;
        frame_node = ~n;
    endtask : frm
endmodule : mbsup_master

`default_nettype wire

/* tb/mbsup_top_tb.sv */
`timescale 1ns/1ns
`default_nettype none

module mbsup_top_tb;
    import mbsup_pkg::*;
    logic clk_sys, sys_rst, nv_write_avail, fault_reset, rdv, cf, sr, ft, at, rf, rv, ss, ce, go;
    logic [7:0] rsp, rss, node;
    logic [3:0] bd;
    logic nw;
    logic [55:0] ifs;
    logic [15:0] volt, freq, spd, rdata, rdl;
    logic [1:0] sm, par;
    logic [15:0] exp_q[$];
    int bad_count, n_checks, n;
    wire logic we, re, fv, ec;
    wire logic [15:0] ad, wd;
    wire logic [7:0] fn;

    mbsup_master m (.clk_sys(clk_sys), .reg_wr_en(we), .reg_rd_en(re), .reg_addr(ad),
        .reg_wdata(wd), .frame_rx_valid(fv), .frame_node(fn), .enter_cmd(ec));

    mbsup_top #(.CYC_MS(10)) dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_wr_en(we),
        .reg_rd_en(re), .reg_addr(ad), .reg_wdata(wd), .reg_rdata_q(rdata),
        .reg_rd_valid_q(rdv), .frame_rx_valid(fv), .frame_node(fn), .enter_cmd(ec),
        .nv_write_avail(nv_write_avail), .fault_reset(fault_reset), .resp_tx_go_q(go),
        .nv_write_q(nw), .run_source_select_primary(rsp), .run_source_select_secondary(rss),
        .input_function_select(ifs), .volt_ref_mon(volt), .freq_mon(freq),
        .speed_mon(spd), .comm_fault_q(cf), .stop_request_q(sr), .stop_method_q(sm),
        .fault_terminal_q(ft), .alarm_terminal_q(at), .run_fwd_q(rf), .run_rev_q(rv),
        .speed_search_req_q(ss), .setting_conflict_error_q(ce), .node_address_q(node),
        .baud_rate_select_q(bd), .parity_select_q(par), .response_delay_q(rdl));

    // Clock
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk

    // Reads note the expected word; the watcher below compares it
    task automatic rd(input logic [15:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        m.acc(1'b0, a, 16'h0000);
    endtask : rd

    task automatic finish_test();
        $display("checks=%0d mismatches=%0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : finish_test

    // Read watcher, one pop per valid pulse
    always @(negedge clk_sys)
        if (rdv === 1'b1)
            chk(rdata, (exp_q.size() > 0) ? exp_q.pop_front() : 16'hDEAD);

    // Watchdog, well beyond the expected few thousand cycles
    initial
    begin
        #200000;
        bad_count++;
        finish_test();
    end

    initial
    begin
        {nv_write_avail, fault_reset} = 2'h0;
        {rsp, rss, ifs} = '0;
        void'($urandom(32'h3cee6f81));
        volt = 16'($urandom);
        freq = 16'($urandom);
        spd = 16'($urandom);
        sys_rst = 1'b1;
        repeat (5) @(negedge clk_sys);
        sys_rst = 1'b0;
        rd(ADDR_TDET, 16'h0001);
        rd(ADDR_TPER, 16'h0014);
        rd(ADDR_RDLY, 16'h0005);
        rd(16'h0FFF, 16'h0000);
        rd(ADDR_VMON, volt);
        rd(ADDR_FREQ_A, freq);
        rd(ADDR_SPD_C, spd);
        // Run bits ignored until the link is a run source
        m.acc(1'b1, ADDR_RUNCMD, 16'h0001);
        repeat (2) @(negedge clk_sys);
        chk(rf, 1'b0);
        rss = RUN_SRC_LINK;
        repeat (2) @(negedge clk_sys);
        chk({rf, rv}, 2'b10);
        // Pending writes, Enter dropped while storage is busy
        m.acc(1'b1, ADDR_RUNENC, 16'h0001);
        m.acc(1'b1, ADDR_VUNIT, 16'h0001);
        m.acc(1'b1, ADDR_COMMIT, 16'h0001);
        m.acc(1'b1, ADDR_RUNCMD, 16'h0003);
        m.ent();
        chk(nw, 1'b0);
        repeat (2) @(negedge clk_sys);
        chk({rf, rv}, 2'b11);
        nv_write_avail = 1'b1;
        m.ent();
        chk(nw, 1'b1);
        repeat (2) @(negedge clk_sys);
        chk({rf, rv}, 2'b01);
        rd(ADDR_VMON, volt / 16'd10);
        // Mode 1: node written at once, activated only by reload
        m.acc(1'b1, ADDR_NODE, 16'h0005);
        m.acc(1'b1, ADDR_PARITY, 16'(PARITY_ODD));
        repeat (2) @(negedge clk_sys);
        chk(node, 16'h001F);
        m.acc(1'b1, ADDR_RELOAD, 16'h0001);
        repeat (2) @(negedge clk_sys);
        chk(node, 16'h0005);
        chk({bd, par}, {4'h3, PARITY_ODD});
        chk(rdl, 16'h0005);
        rd(ADDR_RELOAD, 16'h0000);
        // Speed search request and input conflict
        m.acc(1'b1, ADDR_SSREQ, 16'h0001);
        repeat (2) @(negedge clk_sys);
        chk(ss, 1'b0);
        m.acc(1'b1, ADDR_SSE, 16'h0001);
        repeat (2) @(negedge clk_sys);
        chk(ss, 1'b1);
        ifs[15:8] = IN_FUNC_SSEARCH;
        repeat (2) @(negedge clk_sys);
        chk(ce, 1'b1);
        // Reply delay then timeout of 100 ms, alarm only on the first pass, coast on the second
        m.acc(1'b1, ADDR_TPER, 16'h0001);
        for (int s = 0; s < 2; s++)
        begin
            m.frm(8'h05);
            n = 0;
            while (go !== 1'b1 && n < 80)
            begin
                @(negedge clk_sys);
                n++;
            end
            chk(16'(n >= 49 && n <= 53), 16'h0001);
            repeat (850) @(negedge clk_sys);
            chk(cf, 1'b0);
            repeat (200) @(negedge clk_sys);
            chk({cf, sr, ft, at}, s ? 4'hE : 4'h9);
            chk(sm, s ? STOP_COAST : STOP_ALARM);
            // Restart the timer first, or the expired count raises the fault again
            m.frm(8'h00);
            fault_reset = 1'b1;
            m.acc(1'b1, ADDR_STOP, 16'(STOP_COAST));
            fault_reset = 1'b0;
        end
        // Detection off and node 0: no fault and no reply well past the period
        m.acc(1'b1, ADDR_TDET, 16'h0000);
        m.acc(1'b1, ADDR_NODE, 16'h0000);
        m.acc(1'b1, ADDR_RELOAD, 16'h0001);
        m.frm(8'h00);
        n = 0;
        repeat (1200) @(negedge clk_sys) if (go === 1'b1) n++;
        chk(16'(n), 16'h0000);
        chk(cf, 1'b0);
        repeat (3) @(negedge clk_sys);
        finish_test();
    end
endmodule : mbsup_top_tb

`default_nettype wire
